// file: logic/camera_seq_timer.sv
// Sequence timer, raster timing and phase enables of the slow-scan camera
//
// Overview of operation
// - One 12.5 ms sync pulse per 4-pps line
// - Line: 237.5 ms sweep then 12.5 ms blanking
// - Sweep and blanking run through whole sequence
// - Sync pulses also gate the video switch
// - 4 kHz fast scan only in prepare-expose-delay
// - 10-bit staircase count steps each 250 ms
// - Staircase muted in prepare-expose-delay, 600 steps
// - Staircase count preset to 200 at readout
// - Control grid switch pulses at phase boundaries
// - Target relay driven low only in prepare
// - Flood lamp on 1 s in prepare only
// - Readout sampling pulses 26 us at 4800 pps
// - Sampling pulses blanked during horizontal retrace
// - Sampling pulses grounded in hold and prepare-expose-delay
// - 208-1/3 us period, 1140 samples per line
// - Sample starts 50 us clamp release one-shot
// - Start tone routed first 3 s
// - Then phasing pulses until prepare-expose-delay ends
// - Readout routes camera video only
// - Detector blanked during retrace for DC restore
`timescale 1ns/1ps
`include "camera_map.svh"
module camera_seq_timer #(
  parameter int LINE_CYC = `LINE_CYC,
  parameter int BLANK_CYC = `BLANK_CYC,
  parameter int FAST_HALF_CYC = `FAST_HALF_CYC,
  parameter int SAMPLE_WIDTH = `SAMPLE_WIDTH_CYC,
  parameter int CLAMP_WIDTH = `CLAMP_CYC
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output camera_pkg::phase_t phase,
  output logic hblank,
  output logic video_gate_sync,
  output logic detector_blank,
  output logic fast_scan_en,
  output logic fast_scan_osc,
  output logic [9:0] staircase,
  output logic staircase_en,
  output logic control_grid_pulse,
  output logic target_relay_n,
  output logic flood_lamp_en,
  output camera_pkg::video_src_t video_src,
  output logic sample_pulse,
  output logic clamp_release
);
  import camera_pkg::*;

  sample_if sif ();

  // =====================================================================
  // Line timer, free running so sweep never stops
  logic [24:0] line_cnt;
  logic [24:0] next_line_cnt;
  logic line_tick;
  logic next_hblank;

  always_comb begin
    line_tick = (line_cnt == 25'(LINE_CYC - 1));
    next_line_cnt = line_tick ? 25'h0 : line_cnt + 25'h1;
    next_hblank = (next_line_cnt >= 25'(LINE_CYC - BLANK_CYC));
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      line_cnt <= 25'h0;
      hblank <= 1'b0;
      video_gate_sync <= 1'b0;
      detector_blank <= 1'b0;
    end else begin
      line_cnt <= next_line_cnt;
      hblank <= next_hblank;
      video_gate_sync <= next_hblank;
      detector_blank <= next_hblank;
    end
  end

  // =====================================================================
  // APB slave
  logic start_req;
  logic next_start_req;
  logic repeat_en;
  logic next_repeat_en;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic wr_ctrl;
  logic start_taken;
  logic [9:0] ph_lines;
  logic [9:0] ped_lines;
  logic [9:0] stair;
  localparam logic [31:0] CTRL_INIT = `CTRL_RESET;

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == `REG_CTRL) || (a == `REG_STATUS) || (a == `REG_STAIR) || (a == `REG_LINES);
  endfunction

  always_comb begin
    wr_ctrl = psel && penable && pready && pwrite && (paddr == `REG_CTRL);
    next_pready = psel && !penable;
    next_pslverr = psel && !penable && !addr_ok(paddr);
    next_prdata = prdata;
    if (psel && !penable) begin
      unique case (paddr)
        `REG_CTRL: next_prdata = {30'h0, repeat_en, start_req};
        `REG_STATUS: next_prdata = {27'h0, phase};
        `REG_STAIR: next_prdata = {22'h0, stair};
        `REG_LINES: next_prdata = {6'h0, ped_lines, 6'h0, ph_lines};
        default: next_prdata = 32'h0;
      endcase
    end
    next_repeat_en = wr_ctrl ? pwdata[`CTRL_REPEAT_BIT] : repeat_en;
    // A start written while the pending one is taken stays pending
    next_start_req = start_req;
    if (start_taken) begin
      next_start_req = 1'b0;
    end
    if (wr_ctrl && pwdata[`CTRL_START_BIT]) begin
      next_start_req = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      start_req <= CTRL_INIT[`CTRL_START_BIT];
      repeat_en <= CTRL_INIT[`CTRL_REPEAT_BIT];
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      start_req <= next_start_req;
      repeat_en <= next_repeat_en;
    end
  end

  // =====================================================================
  // Phase sequencer
  phase_t ph;
  phase_t next_ph;
  logic [9:0] next_ph_lines;
  logic [9:0] next_ped_lines;
  logic [9:0] next_stair;
  logic in_ped;
  logic next_in_ped;

  function automatic logic last_line(input logic [9:0] n, input int len);
    last_line = (n == 10'(len - 1));
  endfunction

  always_comb begin
    next_ph = ph;
    next_ph_lines = ph_lines;
    next_ped_lines = ped_lines;
    next_stair = stair;
    start_taken = 1'b0;
    if (line_tick) begin
      next_ph_lines = ph_lines + 10'h1;
      unique case (ph)
        PH_HOLD: begin
          if (start_req || repeat_en) begin
            next_ph = PH_PREPARE;
            start_taken = start_req;
            next_ped_lines = 10'h0;
            next_stair = 10'h0;
          end
        end
        PH_PREPARE: begin
          if (last_line(ph_lines, `PREPARE_LINES)) begin
            next_ph = PH_EXPOSE;
          end
        end
        PH_EXPOSE: begin
          if (last_line(ph_lines, `EXPOSE_LINES)) begin
            next_ph = PH_DELAY;
          end
        end
        PH_DELAY: begin
          if (last_line(ph_lines, `DELAY_LINES)) begin
            next_ph = PH_READOUT;
          end
        end
        PH_READOUT: begin
          if (last_line(ph_lines, `READOUT_LINES)) begin
            next_ph = PH_HOLD;
          end
        end
        default: next_ph = PH_HOLD;
      endcase
      if (ph != PH_HOLD) begin
        next_stair = stair + 10'h1;
      end
      if (ph != PH_HOLD && ph != PH_READOUT) begin
        next_ped_lines = ped_lines + 10'h1;
      end
      if (next_ph != ph) begin
        next_ph_lines = 10'h0;
      end
      if (next_ph == PH_READOUT && ph != PH_READOUT) begin
        next_stair = `STAIR_PRESET;
      end
    end
    next_in_ped = (next_ph == PH_PREPARE) || (next_ph == PH_EXPOSE) || (next_ph == PH_DELAY);
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ph <= PH_HOLD;
      ph_lines <= 10'h0;
      ped_lines <= 10'h0;
      stair <= 10'h0;
      in_ped <= 1'b0;
    end else begin
      ph <= next_ph;
      ph_lines <= next_ph_lines;
      ped_lines <= next_ped_lines;
      stair <= next_stair;
      in_ped <= next_in_ped;
    end
  end

  // =====================================================================
  // Phase enables, registered from the next phase so they change together
  logic [13:0] fast_cnt;
  logic [13:0] next_fast_cnt;
  logic next_fast_osc;
  video_src_t next_video_src;

  always_comb begin
    next_fast_cnt = 14'h0;
    next_fast_osc = 1'b0;
    if (next_in_ped) begin
      next_fast_cnt = fast_cnt + 14'h1;
      next_fast_osc = fast_scan_osc;
      if (fast_cnt == 14'(FAST_HALF_CYC - 1)) begin
        next_fast_cnt = 14'h0;
        next_fast_osc = !fast_scan_osc;
      end
    end
    next_video_src = VSRC_NONE;
    if (next_ph == PH_READOUT) begin
      next_video_src = VSRC_VIDEO;
    end else if (next_in_ped && next_ped_lines < 10'(`TONE_LINES)) begin
      next_video_src = VSRC_TONE;
    end else if (next_in_ped) begin
      next_video_src = VSRC_PHASING;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      phase <= PH_HOLD;
      fast_cnt <= 14'h0;
      fast_scan_osc <= 1'b0;
      fast_scan_en <= 1'b0;
      staircase <= 10'h0;
      staircase_en <= 1'b0;
      control_grid_pulse <= 1'b0;
      target_relay_n <= 1'b1;
      flood_lamp_en <= 1'b0;
      video_src <= VSRC_NONE;
    end else begin
      phase <= next_ph;
      fast_cnt <= next_fast_cnt;
      fast_scan_osc <= next_fast_osc;
      fast_scan_en <= next_in_ped;
      staircase <= (next_ph == PH_READOUT) ? next_stair : 10'h0;
      staircase_en <= (next_ph == PH_READOUT);
      control_grid_pulse <= (next_ph != ph);
      target_relay_n <= (next_ph != PH_PREPARE);
      flood_lamp_en <= (next_ph == PH_PREPARE) && (next_ped_lines < 10'(`LAMP_LINES));
      video_src <= next_video_src;
    end
  end

  // =====================================================================
  // Sampling pulses, gated to readout sweep only
  logic gate_en;
  logic line_start;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      gate_en <= 1'b0;
      line_start <= 1'b0;
    end else begin
      gate_en <= (next_ph == PH_READOUT) && !next_hblank;
      line_start <= line_tick;
    end
  end

  assign sif.gate_en = gate_en;
  assign sif.line_start = line_start;

  sample_pulse_gen #(
    .SAMPLE_WIDTH(SAMPLE_WIDTH),
    .CLAMP_WIDTH(CLAMP_WIDTH)
  ) u_sample (
    .mclk(mclk),
    .reset_n(reset_n),
    .sif(sif.gen)
  );

  assign sample_pulse = sif.sample;
  assign clamp_release = sif.clamp_release;

  // =====================================================================
  // Checks
  logic [24:0] blank_len;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      blank_len <= 25'h0;
    end else begin
      blank_len <= hblank ? blank_len + 25'h1 : 25'h0;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  blank_width_a: assert property ($fell(hblank) |-> blank_len == 25'(BLANK_CYC))
    else $error("blanking width wrong");
  sync_gate_a: assert property (video_gate_sync == hblank && detector_blank == hblank)
    else $error("sync copies differ from blanking");
  fast_off_a: assert property (phase == PH_READOUT |-> !fast_scan_en && !fast_scan_osc)
    else $error("fast scan active in readout");
  stair_mute_a: assert property (staircase_en != (phase == PH_READOUT) || (!staircase_en && staircase != 10'h0) ? 1'b0 : 1'b1)
    else $error("staircase not muted outside readout");
  stair_load_a: assert property ($rose(staircase_en) |-> staircase == `STAIR_PRESET)
    else $error("staircase not preset at readout");
  stair_step_a: assert property (staircase_en && $past(staircase_en) && staircase != $past(staircase) |-> staircase == $past(staircase) + 10'h1)
    else $error("staircase stepped by more than one");
  grid_pulse_a: assert property (control_grid_pulse == (phase != $past(phase)))
    else $error("grid pulse not at phase change");
  relay_a: assert property (!target_relay_n == (phase == PH_PREPARE))
    else $error("relay driven outside prepare");
  lamp_a: assert property (flood_lamp_en |-> phase == PH_PREPARE)
    else $error("lamp on outside prepare");
  sample_mute_a: assert property (phase != PH_READOUT && $past(phase) != PH_READOUT |-> !sample_pulse)
    else $error("sampling outside readout");
  retrace_mute_a: assert property (hblank && $past(hblank) |-> !sample_pulse)
    else $error("sampling during retrace");
  phase_order_a: assert property (phase != $past(phase) |-> (phase >> 1) == $past(phase) || (phase == PH_HOLD && $past(phase) == PH_READOUT))
    else $error("phase out of order");
  tone_a: assert property (video_src == VSRC_TONE || video_src == VSRC_PHASING |-> fast_scan_en)
    else $error("tone or phasing outside prepare-expose-delay");
  cover_readout_c: cover property ($rose(staircase_en));
  cover_tone_c: cover property (video_src == VSRC_TONE ##1 video_src == VSRC_PHASING);
  cover_hold_c: cover property (phase == PH_READOUT ##1 phase == PH_HOLD);
endmodule

// file: logic/camera_map.svh
// Offsets, field positions, reset values and timing counts of the camera timer
`ifndef CAMERA_MAP_SVH
`define CAMERA_MAP_SVH
// =====================================================================
// Register map (byte addresses on APB)
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_STAIR 8'h08
`define REG_LINES 8'h0c
`define CTRL_START_BIT 0
`define CTRL_REPEAT_BIT 1
`define CTRL_RESET 32'h0000_0000
// =====================================================================
// Clock and times
`define CLK_MHZ 100
`define CLK_NS3 30
`define LINE_US 250000
`define BLANK_US 12500
`define SAMPLE_NS3 625000
`define SAMPLE_WIDTH_US 26
`define CLAMP_US 50
`define FAST_HALF_US 125
`define LINE_CYC (`LINE_US * `CLK_MHZ)
`define BLANK_CYC (`BLANK_US * `CLK_MHZ)
`define SAMPLE_WIDTH_CYC (`SAMPLE_WIDTH_US * `CLK_MHZ)
`define CLAMP_CYC (`CLAMP_US * `CLK_MHZ)
`define FAST_HALF_CYC (`FAST_HALF_US * `CLK_MHZ)
// =====================================================================
// Sequence lengths in lines (one line per 250 ms)
`define PREPARE_LINES 8
`define EXPOSE_LINES 4
`define DELAY_LINES 20
`define READOUT_LINES 600
`define LAMP_LINES 4
`define TONE_LINES 12
`define STAIR_PRESET 10'h0c8
`endif

// file: logic/camera_pkg.sv
// Types shared by the camera sequence timer
package camera_pkg;
  typedef enum logic [4:0] {
    PH_HOLD = 5'b00001,
    PH_PREPARE = 5'b00010,
    PH_EXPOSE = 5'b00100,
    PH_DELAY = 5'b01000,
    PH_READOUT = 5'b10000
  } phase_t;
  typedef enum logic [1:0] {
    VSRC_NONE = 2'h0,
    VSRC_TONE = 2'h1,
    VSRC_PHASING = 2'h2,
    VSRC_VIDEO = 2'h3
  } video_src_t;
endpackage

// file: logic/sample_if.sv
// Link between the sequencer and the sampling pulse generator
`timescale 1ns/1ps
interface sample_if;
  logic gate_en;
  logic line_start;
  logic sample;
  logic clamp_release;
  modport seq (output gate_en, output line_start, input sample, input clamp_release);
  modport gen (input gate_en, input line_start, output sample, output clamp_release);
endinterface

// file: logic/sample_pulse_gen.sv
// Sampling pulse generator with detector clamp one-shot
`timescale 1ns/1ps
`include "camera_map.svh"
module sample_pulse_gen #(
  parameter int SAMPLE_WIDTH = `SAMPLE_WIDTH_CYC,
  parameter int CLAMP_WIDTH = `CLAMP_CYC
) (
  input wire logic mclk,
  input wire logic reset_n,
  sample_if.gen sif
);
  import camera_pkg::*;
  localparam logic [19:0] PERIOD_NS3 = 20'(`SAMPLE_NS3);
  localparam logic [19:0] STEP_NS3 = 20'(`CLK_NS3);
  logic [19:0] acc;
  logic [19:0] next_acc;
  logic [15:0] width_cnt;
  logic [15:0] next_width_cnt;
  logic [15:0] clamp_cnt;
  logic [15:0] next_clamp_cnt;
  logic sample;
  logic next_sample;
  logic clamp_release;
  logic next_clamp_release;
  logic fire;

  // =====================================================================
  // Pulse timing
  always_comb begin
    next_acc = acc + STEP_NS3;
    next_width_cnt = width_cnt;
    next_sample = sample;
    next_clamp_cnt = clamp_cnt;
    next_clamp_release = clamp_release;
    fire = 1'b0;
    if (sif.line_start || !sif.gate_en) begin
      // Preset so the first pulse of a sweep comes two cycles after it opens
      next_acc = PERIOD_NS3 - STEP_NS3;
    end else if (next_acc >= PERIOD_NS3) begin
      // Every wrap of the fractional period fires, whatever the remainder
      next_acc = next_acc - PERIOD_NS3;
      fire = 1'b1;
    end
    if (!sif.gate_en) begin
      next_sample = 1'b0;
      next_width_cnt = 16'h0;
    end else if (fire) begin
      next_sample = 1'b1;
      next_width_cnt = 16'h1;
    end else if (sample && width_cnt == 16'(SAMPLE_WIDTH)) begin
      next_sample = 1'b0;
    end else if (sample) begin
      next_width_cnt = width_cnt + 16'h1;
    end
    if (next_sample && !sample) begin
      next_clamp_release = 1'b1;
      next_clamp_cnt = 16'h1;
    end else if (clamp_release && clamp_cnt == 16'(CLAMP_WIDTH)) begin
      next_clamp_release = 1'b0;
    end else if (clamp_release) begin
      next_clamp_cnt = clamp_cnt + 16'h1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      acc <= 20'h0;
      width_cnt <= 16'h0;
      sample <= 1'b0;
      clamp_cnt <= 16'h0;
      clamp_release <= 1'b0;
    end else begin
      acc <= next_acc;
      width_cnt <= next_width_cnt;
      sample <= next_sample;
      clamp_cnt <= next_clamp_cnt;
      clamp_release <= next_clamp_release;
    end
  end

  assign sif.sample = sample;
  assign sif.clamp_release = clamp_release;

  // =====================================================================
  // Checks
  logic [15:0] hi_len;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hi_len <= 16'h0;
    end else begin
      hi_len <= sample ? hi_len + 16'h1 : 16'h0;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  pulse_width_a: assert property ($fell(sample) && $past(sif.gate_en) |-> hi_len == 16'(SAMPLE_WIDTH))
    else $error("sampling pulse width wrong");
  clamp_open_a: assert property ($rose(sample) |-> clamp_release)
    else $error("clamp not released with sample");
  clamp_shut_a: assert property (!clamp_release |-> !sample)
    else $error("sample while clamp engaged");
  cover_sample_c: cover property ($rose(sample));
endmodule

// file: dv/deflection_chain_model.sv
// Behavioural model of the analog deflection and grid switch chain
`timescale 1ns/1ps
module deflection_chain_model #(
  parameter int HALF = 5
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic hblank,
  input wire logic fast_scan_osc,
  input wire logic [9:0] staircase,
  input wire logic staircase_en,
  input wire logic control_grid_pulse,
  output int lines,
  output int steps,
  output int grid_pulses,
  output int osc_rises,
  output int osc_bad
);
  logic hb_q;
  logic osc_q;
  logic en_q;
  logic [9:0] stair_q;
  int osc_gap;
  // =====================================================================
  // Retraces seen, staircase steps applied, grid switchings, scan periods
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hb_q <= 1'b0;
      osc_q <= 1'b0;
      en_q <= 1'b0;
      stair_q <= 10'h000;
      osc_gap <= 0;
      lines <= 0;
      steps <= 0;
      grid_pulses <= 0;
      osc_rises <= 0;
      osc_bad <= 0;
    end else begin
      hb_q <= hblank;
      osc_q <= fast_scan_osc;
      en_q <= staircase_en;
      stair_q <= staircase;
      osc_gap <= osc_gap + 1;
      if (hblank === 1'b1 && hb_q === 1'b0) lines <= lines + 1;
      if (staircase_en === 1'b1 && en_q === 1'b1 && staircase !== stair_q) steps <= steps + 1;
      if (control_grid_pulse === 1'b1) grid_pulses <= grid_pulses + 1;
      if (fast_scan_osc === 1'b1 && osc_q === 1'b0) begin
        osc_rises <= osc_rises + 1;
        osc_gap <= 1;
        if (osc_rises > 0 && osc_gap != 2 * HALF) osc_bad <= osc_bad + 1;
      end
    end
  end
endmodule

// file: dv/camera_seq_timer_test.sv
// Self-checking testbench of the camera sequence timer
`timescale 1ns/1ps
`include "camera_map.svh"
module camera_seq_timer_test;
  import camera_pkg::*;
  localparam int LINE = 100;
  localparam int BLANK = 10;
  localparam int HALF = 5;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  phase_t phase;
  logic hblank, video_gate_sync, detector_blank, fast_scan_en, fast_scan_osc;
  logic [9:0] staircase;
  logic staircase_en, control_grid_pulse, target_relay_n, flood_lamp_en;
  video_src_t video_src;
  logic sample_pulse, clamp_release;
  int failures = 0;
  int checks = 0;
  int cycles = 0;
  int lines, steps, grid_pulses, osc_rises, osc_bad;
  logic [31:0] rd;
  logic err;
  camera_seq_timer #(.LINE_CYC(LINE), .BLANK_CYC(BLANK), .FAST_HALF_CYC(HALF),
    .SAMPLE_WIDTH(8), .CLAMP_WIDTH(16)) u_dut (
    .mclk(mclk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phase(phase), .hblank(hblank), .video_gate_sync(video_gate_sync),
    .detector_blank(detector_blank), .fast_scan_en(fast_scan_en),
    .fast_scan_osc(fast_scan_osc), .staircase(staircase), .staircase_en(staircase_en),
    .control_grid_pulse(control_grid_pulse), .target_relay_n(target_relay_n),
    .flood_lamp_en(flood_lamp_en), .video_src(video_src), .sample_pulse(sample_pulse),
    .clamp_release(clamp_release));
  deflection_chain_model #(.HALF(HALF)) u_chain (
    .mclk(mclk), .reset_n(reset_n), .hblank(hblank), .fast_scan_osc(fast_scan_osc),
    .staircase(staircase), .staircase_en(staircase_en),
    .control_grid_pulse(control_grid_pulse), .lines(lines), .steps(steps),
    .grid_pulses(grid_pulses), .osc_rises(osc_rises), .osc_bad(osc_bad));
  always #5 mclk = ~mclk;
  // =====================================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 70000) begin
      failures++;
      summarize;
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check(n, 1);
  endtask
  task automatic wait_hb(input logic v, output int n);
    n = 0;
    while (hblank !== v && n < 2 * LINE) begin
      @(negedge mclk);
      n++;
    end
  endtask
  function automatic phase_t after(input phase_t p);
    case (p)
      PH_PREPARE: return PH_EXPOSE;
      PH_EXPOSE: return PH_DELAY;
      PH_DELAY: return PH_READOUT;
      default: return PH_HOLD;
    endcase
  endfunction
  // =====================================================================
  // Scenarios
  task automatic test_reset;
    check(32'(phase), 32'(PH_HOLD));
    check(target_relay_n, 1'b1);
    check({flood_lamp_en, fast_scan_en, staircase_en, sample_pulse, clamp_release}, 0);
    check(32'(video_src), 32'(VSRC_NONE));
    apb(1'b0, `REG_CTRL, 0, rd, err);
    check(rd, `CTRL_RESET);
    apb(1'b1, `REG_STATUS, 32'h0000_001f, rd, err);
    apb(1'b0, `REG_STATUS, 0, rd, err);
    check(rd, 32'h0000_0001);
    apb(1'b1, 8'h10, 32'hffff_ffff, rd, err);
    check(err, 1'b1);
    apb(1'b0, 8'h10, 0, rd, err);
    check({err, rd}, {1'b1, 32'h0000_0000});
    $display("test reset done");
  endtask
  task automatic test_line;
    int n, hi, lo;
    wait_hb(1'b0, n);
    wait_hb(1'b1, n);
    wait_hb(1'b0, hi);
    wait_hb(1'b1, lo);
    check(hi, BLANK);
    check(lo, LINE - BLANK);
    $display("test line done");
  endtask
  task automatic test_sequence;
    int n, prepare_expose_delay_phase, rdc, lp, le, ld, l0, s0, g0;
    int v_ord, v_rel, v_fast, v_st, v_lamp, v_src, v_smp, v_cp;
    int hs, hc;
    logic rdp;
    phase_t prev;
    video_src_t es;
    {prepare_expose_delay_phase, rdc, lp, le, ld, v_ord, v_rel, v_fast, v_st, v_lamp, v_src, v_smp, v_cp} = '0;
    hs = 0;
    hc = 0;
    apb(1'b1, `REG_CTRL, 32'h0000_0001, rd, err);
    n = 0;
    while (phase === PH_HOLD && n < 3 * LINE) begin
      @(negedge mclk);
      n++;
    end
    l0 = lines;
    s0 = steps;
    g0 = grid_pulses;
    prev = PH_PREPARE;
    while (n < 66000) begin
      if (phase !== prev && phase !== after(prev)) v_ord++;
      prev = phase;
      if (phase === PH_HOLD) break;
      rdp = (phase === PH_READOUT);
      if (target_relay_n !== (phase === PH_PREPARE ? 1'b0 : 1'b1)) v_rel++;
      if (fast_scan_en !== !rdp || (rdp && fast_scan_osc !== 1'b0)) v_fast++;
      if (staircase_en !== rdp) v_st++;
      if (staircase !== (rdp ? 10'(200 + rdc / LINE) : 10'h000)) v_st++;
      if (flood_lamp_en !== (phase === PH_PREPARE && prepare_expose_delay_phase < 4 * LINE)) v_lamp++;
      es = rdp ? VSRC_VIDEO : (prepare_expose_delay_phase < 12 * LINE ? VSRC_TONE : VSRC_PHASING);
      if (video_src !== es) v_src++;
      if ((!rdp || hblank !== 1'b0) && sample_pulse !== 1'b0) v_smp++;
      if (!rdp && clamp_release !== 1'b0) v_smp++;
      if (rdp && sample_pulse === 1'b1) hs++;
      if (rdp && clamp_release === 1'b1) hc++;
      if (video_gate_sync !== hblank || detector_blank !== hblank) v_cp++;
      lp += (phase === PH_PREPARE);
      le += (phase === PH_EXPOSE);
      ld += (phase === PH_DELAY);
      if (rdp) rdc++;
      else prepare_expose_delay_phase++;
      @(negedge mclk);
      n++;
    end
    repeat (2) @(negedge mclk);
    check(32'(phase), 32'(PH_HOLD));
    check(v_ord, 0);
    check(lp, 8 * LINE);
    check(le, 4 * LINE);
    check(ld, 20 * LINE);
    check(rdc, 600 * LINE);
    check(v_rel, 0);
    check(v_fast, 0);
    check(osc_bad, 0);
    check(osc_rises >= 319 && osc_rises <= 321, 1'b1);
    check(v_st, 0);
    check(steps - s0, 599);
    check(lines - l0, 632);
    check(grid_pulses - g0, 5);
    check(v_lamp, 0);
    check(v_src, 0);
    check(v_smp, 0);
    check(hs, 600 * 8);
    check(hc, 600 * 16);
    check(v_cp, 0);
    $display("test sequence done");
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    @(negedge mclk);
    test_reset;
    test_line;
    test_sequence;
    summarize;
  end
endmodule
